// ### shared/prio_pkg.sv
// Constants for the second I2C controller priority register block
package prio_pkg;
  // ***************************************************************
  // Bus and register map
  // ***************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam logic [ADDR_W-1:0] PRIO_CTRL_OFFSET = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h004;

  // ***************************************************************
  // Priority fields
  // ***************************************************************
  localparam int PRIO_W = 3;
  localparam int NUM_SRC = 2;
  localparam int CTRL_W = 16;
  localparam int MASTER_LSB = 8;
  localparam int SLAVE_LSB = 4;
  localparam logic [PRIO_W-1:0] PRIO_DISABLED = 3'h0;
  localparam logic [PRIO_W-1:0] PRIO_LEVEL_MAX = 3'h7;
  localparam logic [PRIO_W-1:0] PRIO_LEVEL_MIN = 3'h1;
  localparam logic [PRIO_W-1:0] MASTER_PRIO_RESET = 3'h4;
  localparam logic [PRIO_W-1:0] SLAVE_PRIO_RESET = 3'h4;
  localparam logic [CTRL_W-1:0] CTRL_IMPL_MASK = 16'h0770;

  // ***************************************************************
  // Sources and status layout
  // ***************************************************************
  localparam logic SRC_MASTER = 1'h0;
  localparam logic SRC_SLAVE = 1'h1;
  localparam int STAT_REQ_BIT = 0;
  localparam int STAT_LEVEL_LSB = 4;
  localparam int STAT_SRC_BIT = 8;
endpackage : prio_pkg

// ### rtl/prio_arbiter.sv
// Combinational priority arbiter for the two I2C event sources
`timescale 1ns/10ps
`default_nettype none
module prio_arbiter
  import prio_pkg::*;
(
  // Source requests and their priority codes
  input wire logic [prio_pkg::NUM_SRC-1:0] pending,
  input wire logic [prio_pkg::NUM_SRC-1:0][prio_pkg::PRIO_W-1:0] prio,
  // Winner
  output logic grant_valid,
  output logic grant_id,
  output logic [prio_pkg::PRIO_W-1:0] grant_level
);
  logic [NUM_SRC-1:0] eligible;

  // A code of zero masks the source entirely
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_elig
      assign eligible[g] = pending[g] && (prio[g] != PRIO_DISABLED);
    end
  endgenerate

  // Highest code wins; lower index wins a tie, so the master source goes first
  always_comb
  begin
    grant_valid = 1'b0;
    grant_id = SRC_MASTER;
    grant_level = PRIO_DISABLED;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (eligible[i] && (prio[i] > grant_level))
      begin
        grant_valid = 1'b1;
        grant_id = i[0];
        grant_level = prio[i];
      end
    end
  end
endmodule : prio_arbiter
`default_nettype wire

// ### rtl/serial_irq_priority_regs.sv
// APB priority control register for the second I2C controller with arbitration
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
`default_nettype none

// Contract
// - Nonzero priority codes mean levels one to seven, seven being the highest.
// - A code of zero disables its source so that it never requests service.
// - The master event priority field sits in bits 10 to 8 and is read-write.
// - The slave event priority field sits in bits 6 to 4 and is read-write.
module serial_irq_priority_regs
  import prio_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // APB slave
  input wire logic [prio_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [prio_pkg::DATA_W-1:0] pwdata,
  input wire logic [prio_pkg::STRB_W-1:0] pstrb,
  output logic [prio_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event requests from the I2C controller
  input wire logic master_event_pending,
  input wire logic slave_event_pending,
  // Priority values and arbitration result
  output logic [prio_pkg::PRIO_W-1:0] i2c_master_event_priority,
  output logic [prio_pkg::PRIO_W-1:0] i2c_slave_event_priority,
  output logic irq_request,
  output logic irq_source,
  output logic [prio_pkg::PRIO_W-1:0] irq_level
);
  import prio_pkg::*;

  // ***************************************************************
  // Bus decode
  // ***************************************************************
  logic setup_phase;
  logic access_phase;
  logic hit_ctrl;
  logic hit_status;
  logic wr_ctrl;

  assign setup_phase = psel && !penable;
  assign access_phase = psel && penable;
  assign hit_ctrl = (paddr == PRIO_CTRL_OFFSET);
  assign hit_status = (paddr == STATUS_OFFSET);
  assign wr_ctrl = access_phase && pwrite && hit_ctrl;

  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  // Unmapped addresses and writes to the read-only status answer with an error
  assign pslverr = access_phase && !(hit_ctrl || (hit_status && !pwrite));

  // ***************************************************************
  // Priority control register
  // ***************************************************************
  logic [PRIO_W-1:0] next_master_prio;
  logic [PRIO_W-1:0] next_slave_prio;

  // Only the two fields exist as flops; the other bits have no storage at all
  always_comb
  begin
    next_master_prio = i2c_master_event_priority;
    next_slave_prio = i2c_slave_event_priority;
    if (wr_ctrl && pstrb[1])
    begin
      next_master_prio = pwdata[MASTER_LSB +: PRIO_W];
    end
    if (wr_ctrl && pstrb[0])
    begin
      next_slave_prio = pwdata[SLAVE_LSB +: PRIO_W];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      i2c_master_event_priority <= MASTER_PRIO_RESET;
      i2c_slave_event_priority <= SLAVE_PRIO_RESET;
    end
    else
    begin
      i2c_master_event_priority <= next_master_prio;
      i2c_slave_event_priority <= next_slave_prio;
    end
  end

  // ***************************************************************
  // Arbitration
  // ***************************************************************
  logic grant_valid;
  logic grant_id;
  logic [PRIO_W-1:0] grant_level;
  logic next_irq_request;
  logic next_irq_source;
  logic [PRIO_W-1:0] next_irq_level;

  prio_arbiter u_arbiter (
    .pending ({slave_event_pending, master_event_pending}),
    .prio ({i2c_slave_event_priority, i2c_master_event_priority}),
    .grant_valid (grant_valid),
    .grant_id (grant_id),
    .grant_level (grant_level)
  );

  // Registered result costs one cycle of latency but gives glitch-free outputs
  always_comb
  begin
    next_irq_request = grant_valid;
    next_irq_source = grant_id;
    next_irq_level = grant_level;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_request <= 1'b0;
      irq_source <= SRC_MASTER;
      irq_level <= PRIO_DISABLED;
    end
    else
    begin
      irq_request <= next_irq_request;
      irq_source <= next_irq_source;
      irq_level <= next_irq_level;
    end
  end

  // ***************************************************************
  // Read data
  // ***************************************************************
  logic [DATA_W-1:0] next_prdata;
  logic [CTRL_W-1:0] ctrl_view;

  // Unused positions are tied to zero, and the mask guards the view as well
  always_comb
  begin
    ctrl_view = '0;
    ctrl_view[MASTER_LSB +: PRIO_W] = i2c_master_event_priority;
    ctrl_view[SLAVE_LSB +: PRIO_W] = i2c_slave_event_priority;
    ctrl_view = ctrl_view & CTRL_IMPL_MASK;
    next_prdata = prdata;
    if (setup_phase && !pwrite)
    begin
      next_prdata = '0;
      if (hit_ctrl)
      begin
        next_prdata[CTRL_W-1:0] = ctrl_view;
      end
      else if (hit_status)
      begin
        next_prdata[STAT_REQ_BIT] = irq_request;
        next_prdata[STAT_LEVEL_LSB +: PRIO_W] = irq_level;
        next_prdata[STAT_SRC_BIT] = irq_source;
      end
    end
  end

  // Read data is captured in the setup cycle so it stands as a flop in the access cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= '0;
    end
    else
    begin
      prdata <= next_prdata;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_ctrl_write_hi;
    wr_ctrl && pstrb[1];
  endsequence

  sequence s_ctrl_write_lo;
    wr_ctrl && pstrb[0];
  endsequence

  sequence s_ctrl_read;
    setup_phase && !pwrite && hit_ctrl ##1 access_phase && !pwrite && hit_ctrl;
  endsequence

  a_level_follows_code: assert property (
    irq_request |-> (irq_level >= PRIO_LEVEL_MIN) && (irq_level <= PRIO_LEVEL_MAX)
      && (irq_level == (irq_source ? $past(i2c_slave_event_priority) : $past(i2c_master_event_priority))))
    else $error("granted level differs from source code");

  a_disabled_never_requests: assert property (
    (i2c_master_event_priority == PRIO_DISABLED) && (i2c_slave_event_priority == PRIO_DISABLED)
      |=> !irq_request)
    else $error("request raised with both sources disabled");

  a_master_field_write: assert property (
    s_ctrl_write_hi |=> i2c_master_event_priority == $past(pwdata[MASTER_LSB +: PRIO_W]))
    else $error("master priority field not written");

  a_slave_field_write: assert property (
    s_ctrl_write_lo |=> i2c_slave_event_priority == $past(pwdata[SLAVE_LSB +: PRIO_W]))
    else $error("slave priority field not written");

  a_reserved_read_zero: assert property (
    s_ctrl_read |-> (prdata[DATA_W-1:11] == '0) && !prdata[7] && (prdata[3:0] == '0)
      && (prdata[10:8] == $past(i2c_master_event_priority)))
    else $error("reserved bits read nonzero or field wrong");

  a_highest_wins: assert property (
    master_event_pending && slave_event_pending && (i2c_slave_event_priority > i2c_master_event_priority)
      |=> irq_request && (irq_source == SRC_SLAVE))
    else $error("higher slave level lost arbitration");

  a_tie_natural_order: assert property (
    master_event_pending && slave_event_pending && (i2c_master_event_priority != PRIO_DISABLED)
      && (i2c_slave_event_priority == i2c_master_event_priority)
      |=> irq_request && (irq_source == SRC_MASTER))
    else $error("tie not broken toward master source");

  a_disabled_master_idle: assert property (
    master_event_pending && (i2c_master_event_priority == PRIO_DISABLED) && !slave_event_pending
      |=> !irq_request ##1 1'b1)
    else $error("disabled master source requested service");
endmodule : serial_irq_priority_regs
`default_nettype wire

// ### test/event_source_model.sv
// Model of the I2C controller that raises the two event request lines
`timescale 1ns/10ps
`default_nettype none
module event_source_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Requests from the bench
  input wire logic want_master,
  input wire logic want_slave,
  // Event lines to the block
  output logic master_event_pending,
  output logic slave_event_pending
);
  // Registered, as a real controller raises its lines after its own edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      master_event_pending <= 1'b0;
      slave_event_pending <= 1'b0;
    end
    else
    begin
      master_event_pending <= want_master;
      slave_event_pending <= want_slave;
    end
  end
endmodule : event_source_model
`default_nettype wire

// ### test/serial_irq_priority_regs_tb.sv
// Testbench for the I2C priority register block
`timescale 1ns/10ps
`default_nettype none
module serial_irq_priority_regs_tb;
  import prio_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [STRB_W-1:0] strb = 4'hf;
  logic [DATA_W-1:0] pwdata = '0, prdata, r;
  logic pready, pslverr, e, mp, sp, want_m = 1'b0, want_s = 1'b0, req, src;
  logic [PRIO_W-1:0] mf, sf, lvl, xl;
  logic [PRIO_W-1:0] tm [0:5] = '{3'h7, 3'h1, 3'h3, 3'h0, 3'h5, 3'h0};
  logic [PRIO_W-1:0] ts [0:5] = '{3'h1, 3'h7, 3'h3, 3'h5, 3'h0, 3'h0};
  int n_errors = 0, num_checks = 0, cyc = 0;
  serial_irq_priority_regs i_dut (.clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_event_pending(mp), .slave_event_pending(sp), .i2c_master_event_priority(mf),
    .i2c_slave_event_priority(sf), .irq_request(req), .irq_source(src), .irq_level(lvl));
  event_source_model i_src (.clk(clk), .rstn(rstn), .want_master(want_m), .want_slave(want_s),
    .master_event_pending(mp), .slave_event_pending(sp));
  // 10 MHz clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  // Cut a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  // Compare one value
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    num_checks = num_checks + 1;
    if (s !== x)
    begin
      n_errors = n_errors + 1;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask : chk
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // Only the bench timeout ends a wait for the slave's answer
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    apb(PRIO_CTRL_OFFSET, 1'b0, '0);
    chk("reset word", r, 32'h440);
    chk("read error", 32'(e), 32'h0);
    chk("reset master field", 32'(mf), 32'h4);
    chk("reset slave field", 32'(sf), 32'h4);
    $display("test reset done");
    apb(PRIO_CTRL_OFFSET, 1'b1, 32'hffffffff);
    chk("write error", 32'(e), 32'h0);
    apb(PRIO_CTRL_OFFSET, 1'b0, '0);
    chk("all ones word", r, 32'h770);
    chk("all ones master", 32'(mf), 32'h7);
    $display("test unused bits done");
    // Low lane only: the slave field takes the write, the master field keeps its value
    strb <= 4'h1;
    apb(PRIO_CTRL_OFFSET, 1'b1, 32'h0);
    strb <= 4'hf;
    apb(PRIO_CTRL_OFFSET, 1'b0, '0);
    chk("low lane word", r, 32'h700);
    chk("low lane slave", 32'(sf), 32'h0);
    $display("test byte lanes done");
    want_m <= 1'b1;
    want_s <= 1'b1;
    // Priority pairs: strict wins both ways, a tie, each side disabled, both disabled
    for (int i = 0; i < 6; i++)
    begin
      apb(PRIO_CTRL_OFFSET, 1'b1, {20'h0, 1'b0, tm[i], 1'b0, ts[i], 4'h0});
      repeat (3) @(posedge clk);
      xl = (ts[i] > tm[i]) ? ts[i] : tm[i];
      chk("request", 32'(req), 32'(xl != 3'h0));
      chk("level", 32'(lvl), 32'(xl));
      chk("source", 32'(src), 32'(ts[i] > tm[i]));
      chk("slave field", 32'(sf), 32'(ts[i]));
      apb(STATUS_OFFSET, 1'b0, '0);
      chk("status", r, {23'h0, ts[i] > tm[i], 1'b0, xl, 3'h0, xl != 3'h0});
      chk("status error", 32'(e), 32'h0);
    end
    $display("test arbitration done");
    apb(12'h008, 1'b0, '0);
    chk("unmapped error", 32'(e), 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(STATUS_OFFSET, 1'b1, 32'hffffffff);
    chk("status write error", 32'(e), 32'h1);
    apb(PRIO_CTRL_OFFSET, 1'b0, '0);
    chk("word kept", r, 32'h0);
    $display("test refusals done");
    final_report();
  end
endmodule : serial_irq_priority_regs_tb
`default_nettype wire
